// *** sspseq_top.sv ***
// Purpose: sleep state power sequencer with register port
// Assumes: one clock, rtc count and wake pin as inputs
// Notes: one-hot sequencer, registers hold the per-state supply words
// Notes on behaviour
// - Low wake time register, reset zero, used only with rtc wake while asleep.
// - High wake time register used only with rtc wake and wide compare asleep.
// - Hold state register supplies outputs while sequencer sits in hold state.
// - Five-bit dwell code n means 2^n cycles, resets to 16.
// - Leave hold state after dwell expiry and rtc or pin wake.
// - Dwell advances on enabled clock, slow oscillator or main clock.
// - Bit 14 set gates processor clock in that state, reset 0.
// - Bits 8 and 9 select pulse-frequency mode when set, reset 0.
// - Bits 5, 4, 0 enable io supply, pll regulator, core regulator.
// - Bit 1 analogue regulator enable is read-only fixed value.
// - First transition register resets with io and analogue enables set.
// - Second transition register holds supplies and dwell for that state.
// - Three-bit pll level code, 100 mV steps from 0.6V, reset from pin.
// - Control bit 4 enables rtc wake, reset 0.
// - Control bit 5 enables 64-bit compare, reset 0.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module sspseq_top (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic [63:0] rtc_in,
    input wire logic wake_pin_in,
    input wire logic [2:0] pll_level_strap_in,
    output logic core_en_out,
    output logic ana_en_out,
    output logic pll_en_out,
    output logic io_en_out,
    output logic core_pfm_out,
    output logic ana_pfm_out,
    output logic clk_gate_out,
    output logic [2:0] pll_level_out,
    output logic [3:0] state_out
);
    import sspseq_pkg::*;

    logic [31:0] ctrl_q;
    logic [31:0] wake_lo_q;
    logic [31:0] wake_hi_q;
    logic [31:0] hold_q;
    logic [31:0] first_q;
    logic [31:0] second_q;
    logic [2:0] pll_lvl_q;
    logic strap_done_q;
    logic [1:0] pin_sync_q;
    logic [2:0] strap_s1_q;
    logic [2:0] strap_s2_q;
    sspseq_state_t state_q;
    sspseq_state_t state_d;
    logic slow_tick;
    logic dwell_tick;
    logic dwell_done;
    logic dwell_start;
    logic sleep_go;
    logic rtc_hit;
    logic pin_hit;
    logic [31:0] cur_cfg;
    logic [31:0] next_cfg;

    // Pin and strap come from outside the clock domain
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pin_sync_q <= 2'h0;
        end else begin
            pin_sync_q <= {pin_sync_q[0], wake_pin_in};
        end
    end

    // Strap stages run through reset, so the first edge after release sees the pin
    always_ff @(posedge clk_in) begin
        strap_s1_q <= pll_level_strap_in;
        strap_s2_q <= strap_s1_q;
    end

    function automatic logic [31:0] wr_field(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [31:0] mask);
        wr_field = (old & ~mask) | (nw & mask);
    endfunction : wr_field

    function automatic logic [31:0] cfg_of(input sspseq_state_t s, input logic [31:0] h,
                                           input logic [31:0] f, input logic [31:0] t);
        case (s)
            SSPSEQ_FIRST: cfg_of = f;
            SSPSEQ_SECOND: cfg_of = t;
            SSPSEQ_HOLD: cfg_of = h;
            // Awake keeps every supply on, matching the reset levels
            default: cfg_of = 32'h0000_0033;
        endcase
    endfunction : cfg_of

    function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] o);
        wr_hit = wr && (a == o);
    endfunction : wr_hit

    assign sleep_go = wr_hit(wr_in, addr_in, SSPSEQ_OFF_CTRL) && wdata_in[SSPSEQ_CTRL_SLEEP_GO]
                      && (state_q == SSPSEQ_AWAKE);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ctrl_q <= SSPSEQ_CTRL_RST;
        end else if (wr_hit(wr_in, addr_in, SSPSEQ_OFF_CTRL)) begin
            ctrl_q <= wr_field(ctrl_q, wdata_in, SSPSEQ_CTRL_WMASK);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wake_lo_q <= SSPSEQ_WAKE_RST;
            wake_hi_q <= SSPSEQ_WAKE_RST;
        end else begin
            if (wr_hit(wr_in, addr_in, SSPSEQ_OFF_WAKE_LO)) begin
                wake_lo_q <= wdata_in;
            end
            if (wr_hit(wr_in, addr_in, SSPSEQ_OFF_WAKE_HI)) begin
                wake_hi_q <= wdata_in;
            end
        end
    end

    // Bit 1 is outside the write mask, so it keeps its reset value
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            hold_q <= SSPSEQ_HOLD_RST;
            first_q <= SSPSEQ_FIRST_RST;
            second_q <= SSPSEQ_SECOND_RST;
        end else begin
            if (wr_hit(wr_in, addr_in, SSPSEQ_OFF_HOLD)) begin
                hold_q <= wr_field(hold_q, wdata_in, SSPSEQ_CFG_WMASK);
            end
            if (wr_hit(wr_in, addr_in, SSPSEQ_OFF_FIRST)) begin
                first_q <= wr_field(first_q, wdata_in, SSPSEQ_CFG_WMASK);
            end
            if (wr_hit(wr_in, addr_in, SSPSEQ_OFF_SECOND)) begin
                second_q <= wr_field(second_q, wdata_in, SSPSEQ_CFG_WMASK);
            end
        end
    end

    // Strap is taken once after release; a write in that same cycle wins and the strap is skipped
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pll_lvl_q <= 3'h0;
            strap_done_q <= 1'b0;
        end else if (wr_hit(wr_in, addr_in, SSPSEQ_OFF_PLL_LVL)) begin
            pll_lvl_q <= wdata_in[2:0];
            strap_done_q <= 1'b1;
        end else if (!strap_done_q) begin
            pll_lvl_q <= strap_s2_q;
            strap_done_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (rd_in) begin
            case (addr_in)
                SSPSEQ_OFF_CTRL: rdata_out <= ctrl_q;
                SSPSEQ_OFF_WAKE_LO: rdata_out <= wake_lo_q;
                SSPSEQ_OFF_WAKE_HI: rdata_out <= wake_hi_q;
                SSPSEQ_OFF_HOLD: rdata_out <= hold_q;
                SSPSEQ_OFF_FIRST: rdata_out <= first_q;
                SSPSEQ_OFF_SECOND: rdata_out <= second_q;
                SSPSEQ_OFF_PLL_LVL: rdata_out <= {29'h0, pll_lvl_q};
                SSPSEQ_OFF_STATUS: rdata_out <= {28'h0, state_q};
                default: rdata_out <= 32'h0000_0000;
            endcase
        end else begin
            rdata_out <= 32'h0000_0000;
        end
    end

    // Compare only counts while asleep with rtc wake on
    assign rtc_hit = ctrl_q[SSPSEQ_CTRL_RTC_EN] && (state_q == SSPSEQ_HOLD)
                     && (rtc_in[31:0] == wake_lo_q)
                     && (!ctrl_q[SSPSEQ_CTRL_WIDE] || (rtc_in[63:32] == wake_hi_q));
    assign pin_hit = ctrl_q[SSPSEQ_CTRL_PIN_EN]
                     && (pin_sync_q[1] == ctrl_q[SSPSEQ_CTRL_PIN_POL]);

    sspseq_tick u_tick (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .tick_out(slow_tick)
    );

    // Slow clock only in hold state unless software picks the main clock
    assign dwell_tick = (state_q == SSPSEQ_HOLD && !ctrl_q[SSPSEQ_CTRL_SLEEP_CLK])
                        ? slow_tick : 1'b1;

    always_comb begin
        state_d = state_q;
        case (state_q)
            SSPSEQ_AWAKE: begin
                if (sleep_go) begin
                    state_d = SSPSEQ_FIRST;
                end
            end
            SSPSEQ_FIRST: begin
                if (dwell_done) begin
                    state_d = SSPSEQ_SECOND;
                end
            end
            SSPSEQ_SECOND: begin
                if (dwell_done) begin
                    state_d = SSPSEQ_HOLD;
                end
            end
            SSPSEQ_HOLD: begin
                if (dwell_done && (rtc_hit || pin_hit)) begin
                    state_d = SSPSEQ_AWAKE;
                end
            end
            default: state_d = SSPSEQ_AWAKE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_q <= SSPSEQ_AWAKE;
        end else begin
            state_q <= state_d;
        end
    end

    assign dwell_start = (state_d != state_q);
    assign next_cfg = cfg_of(state_d, hold_q, first_q, second_q);
    assign cur_cfg = cfg_of(state_q, hold_q, first_q, second_q);

    sspseq_dwell u_dwell (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .start_in(dwell_start),
        .tick_in(dwell_tick),
        .code_in(next_cfg[SSPSEQ_DWELL_MSB:SSPSEQ_DWELL_LSB]),
        .done_out(dwell_done)
    );

    // Outputs follow the register of the occupied state one cycle later
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            core_en_out <= 1'b1;
            ana_en_out <= 1'b1;
            pll_en_out <= 1'b1;
            io_en_out <= 1'b1;
            core_pfm_out <= 1'b0;
            ana_pfm_out <= 1'b0;
            clk_gate_out <= 1'b0;
            pll_level_out <= 3'h0;
            state_out <= SSPSEQ_AWAKE;
        end else begin
            core_en_out <= cur_cfg[SSPSEQ_BIT_CORE_EN];
            ana_en_out <= cur_cfg[SSPSEQ_BIT_ANA_EN];
            pll_en_out <= cur_cfg[SSPSEQ_BIT_PLL_EN];
            io_en_out <= cur_cfg[SSPSEQ_BIT_IO_EN];
            core_pfm_out <= cur_cfg[SSPSEQ_BIT_CORE_PFM];
            ana_pfm_out <= cur_cfg[SSPSEQ_BIT_ANA_PFM];
            clk_gate_out <= cur_cfg[SSPSEQ_BIT_CLK_GATE];
            pll_level_out <= pll_lvl_q;
            state_out <= state_q;
        end
    end

    // Assertions
    sequence s_asleep_hit;
        state_q == SSPSEQ_HOLD && dwell_done && (rtc_hit || pin_hit);
    endsequence

    a_hold_exit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_asleep_hit |=> state_q == SSPSEQ_AWAKE)
        else $error("hold state not left on wake");
    a_hold_stays: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_q == SSPSEQ_HOLD && !dwell_done) |=> state_q == SSPSEQ_HOLD)
        else $error("hold left before dwell");
    a_rtc_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_q != SSPSEQ_HOLD || !ctrl_q[SSPSEQ_CTRL_RTC_EN]) |-> !rtc_hit)
        else $error("rtc wake outside enabled sleep");
    a_wide_cmp: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (rtc_hit && ctrl_q[SSPSEQ_CTRL_WIDE]) |-> rtc_in[63:32] == wake_hi_q)
        else $error("wide compare ignored high word");
    a_clk_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_q == SSPSEQ_HOLD) |=> clk_gate_out == $past(hold_q[SSPSEQ_BIT_CLK_GATE]))
        else $error("clock gate mismatch in hold");
    a_pfm_sel: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_q == SSPSEQ_SECOND) |=> core_pfm_out == $past(second_q[SSPSEQ_BIT_CORE_PFM]))
        else $error("modulation mismatch");
    a_ana_ro: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        first_q[SSPSEQ_BIT_ANA_EN] && !hold_q[SSPSEQ_BIT_ANA_EN])
        else $error("analogue enable bit changed");
    a_supply_en: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_q == SSPSEQ_FIRST) |=> io_en_out == $past(first_q[SSPSEQ_BIT_IO_EN]))
        else $error("io enable mismatch");
    a_first_dwell: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_q == SSPSEQ_AWAKE && sleep_go
         && first_q[SSPSEQ_DWELL_MSB:SSPSEQ_DWELL_LSB] == 5'h02)
        |=> (state_q == SSPSEQ_FIRST) [*5] ##1 (state_q == SSPSEQ_SECOND))
        else $error("first dwell of four cycles wrong");
    // Entry edge adds one cycle to the four counted ones

    // Dwell may only move on a slow tick while hold uses the slow clock
    sequence s_hold_slow_idle;
        state_q == SSPSEQ_HOLD && !ctrl_q[SSPSEQ_CTRL_SLEEP_CLK] && !slow_tick && !dwell_done;
    endsequence

    sequence s_strap_take;
        rst_n_in && !strap_done_q && !wr_hit(wr_in, addr_in, SSPSEQ_OFF_PLL_LVL);
    endsequence

    a_slow_dwell: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_hold_slow_idle |=> !dwell_done)
        else $error("dwell moved without slow tick");
    a_dwell_reload: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        dwell_start |=> !dwell_done)
        else $error("dwell not reloaded on entry");
    a_sleep_entry: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_q == SSPSEQ_AWAKE && sleep_go) |=> state_q == SSPSEQ_FIRST)
        else $error("sleep request not taken");
    a_hold_supply: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_q == SSPSEQ_HOLD) |=> core_en_out == $past(hold_q[SSPSEQ_BIT_CORE_EN]))
        else $error("core enable mismatch in hold");
    a_hold_pfm: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_q == SSPSEQ_HOLD) |=> ana_pfm_out == $past(hold_q[SSPSEQ_BIT_ANA_PFM]))
        else $error("analogue modulation mismatch in hold");
    a_first_ana: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_q == SSPSEQ_FIRST) |=> ana_en_out == $past(first_q[SSPSEQ_BIT_ANA_EN]))
        else $error("analogue enable mismatch in first state");
    a_first_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_q == SSPSEQ_FIRST) |=> clk_gate_out == $past(first_q[SSPSEQ_BIT_CLK_GATE]))
        else $error("clock gate mismatch in first state");
    a_second_io: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_q == SSPSEQ_SECOND) |=> io_en_out == $past(second_q[SSPSEQ_BIT_IO_EN]))
        else $error("io enable mismatch in second state");
    a_ro_bits: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $stable(hold_q[SSPSEQ_BIT_ANA_EN]) && $stable(first_q[SSPSEQ_BIT_ANA_EN])
        && $stable(second_q[SSPSEQ_BIT_ANA_EN]))
        else $error("read-only analogue bit moved");
    a_rtc_narrow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_q == SSPSEQ_HOLD && ctrl_q[SSPSEQ_CTRL_RTC_EN] && !ctrl_q[SSPSEQ_CTRL_WIDE]
         && rtc_in[31:0] == wake_lo_q) |-> rtc_hit)
        else $error("narrow rtc match missed");
    a_strap_take: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_strap_take |=> pll_lvl_q == $past(strap_s2_q))
        else $error("strap level not captured");
    a_level_out: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rst_n_in |=> pll_level_out == $past(pll_lvl_q))
        else $error("pll level output mismatch");
endmodule : sspseq_top

// *** sspseq_pkg.sv ***
// Purpose: shared constants for the sleep state power sequencer
// Assumes: 32-bit register port, word offsets as printed
// Notes: supply config layout is common to all three state registers
package sspseq_pkg;
    localparam logic [7:0] SSPSEQ_OFF_CTRL = 8'h00;
    localparam logic [7:0] SSPSEQ_OFF_WAKE_LO = 8'h04;
    localparam logic [7:0] SSPSEQ_OFF_WAKE_HI = 8'h08;
    localparam logic [7:0] SSPSEQ_OFF_HOLD = 8'h0C;
    localparam logic [7:0] SSPSEQ_OFF_FIRST = 8'h1C;
    localparam logic [7:0] SSPSEQ_OFF_SECOND = 8'h20;
    localparam logic [7:0] SSPSEQ_OFF_PLL_LVL = 8'h40;
    localparam logic [7:0] SSPSEQ_OFF_STATUS = 8'h44;
    localparam int SSPSEQ_BIT_CORE_EN = 0;
    localparam int SSPSEQ_BIT_ANA_EN = 1;
    localparam int SSPSEQ_BIT_PLL_EN = 4;
    localparam int SSPSEQ_BIT_IO_EN = 5;
    localparam int SSPSEQ_BIT_CORE_PFM = 8;
    localparam int SSPSEQ_BIT_ANA_PFM = 9;
    localparam int SSPSEQ_BIT_CLK_GATE = 14;
    localparam int SSPSEQ_DWELL_LSB = 16;
    localparam int SSPSEQ_DWELL_MSB = 20;
    localparam int SSPSEQ_CTRL_SLEEP_CLK = 0;
    localparam int SSPSEQ_CTRL_SLEEP_GO = 1;
    localparam int SSPSEQ_CTRL_PIN_EN = 2;
    localparam int SSPSEQ_CTRL_PIN_POL = 3;
    localparam int SSPSEQ_CTRL_RTC_EN = 4;
    localparam int SSPSEQ_CTRL_WIDE = 5;
    localparam logic [31:0] SSPSEQ_CFG_WMASK = 32'h001F_4331;
    localparam logic [31:0] SSPSEQ_CTRL_WMASK = 32'h0000_003D;
    localparam logic [31:0] SSPSEQ_CTRL_RST = 32'h0000_0008;
    localparam logic [31:0] SSPSEQ_HOLD_RST = 32'h0010_0000;
    localparam logic [31:0] SSPSEQ_FIRST_RST = 32'h0010_0022;
    localparam logic [31:0] SSPSEQ_SECOND_RST = 32'h0010_0000;
    localparam logic [31:0] SSPSEQ_WAKE_RST = 32'h0000_0000;
    localparam int SSPSEQ_SLOW_DIV = 3200;
    typedef enum logic [3:0] {
        SSPSEQ_AWAKE = 4'b0001,
        SSPSEQ_FIRST = 4'b0010,
        SSPSEQ_SECOND = 4'b0100,
        SSPSEQ_HOLD = 4'b1000
    } sspseq_state_t;
endpackage : sspseq_pkg

// *** sspseq_tick.sv ***
// Purpose: clock enable divider for the slow sleep clock
// Assumes: runs from clk_in
// Notes: one-cycle pulse every DIV cycles
`timescale 1ns/1ps
module sspseq_tick #(
    parameter int DIV = sspseq_pkg::SSPSEQ_SLOW_DIV
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    output logic tick_out
);
    import sspseq_pkg::*;
    logic [15:0] cnt_q;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q <= 16'h0000;
            tick_out <= 1'b0;
        end else if (cnt_q == 16'(DIV - 1)) begin
            cnt_q <= 16'h0000;
            tick_out <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            tick_out <= 1'b0;
        end
    end
endmodule : sspseq_tick

// *** sspseq_dwell.sv ***
// Purpose: dwell counter, 2^n enabled-clock cycles
// Assumes: start pulse reloads, tick advances
// Notes: 32-bit count covers code 31
`timescale 1ns/1ps
module sspseq_dwell (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic tick_in,
    input wire logic [4:0] code_in,
    output logic done_out
);
    import sspseq_pkg::*;
    logic [31:0] cnt_q;
    logic [31:0] lim_q;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q <= 32'h0000_0000;
            lim_q <= 32'h0000_0001;
            done_out <= 1'b0;
        end else if (start_in) begin
            cnt_q <= 32'h0000_0000;
            lim_q <= 32'h0000_0001 << code_in;
            done_out <= 1'b0;
        end else if (tick_in && !done_out) begin
            cnt_q <= cnt_q + 32'h0000_0001;
            done_out <= (cnt_q + 32'h0000_0001) == lim_q;
        end
    end
endmodule : sspseq_dwell

// *** tb.sv ***
// Purpose: self-checking bench for the sleep state power sequencer
// Assumes: slow tick divider at its full value, main clock 100 MHz
// Notes: hold exits are driven through rtc_in and wake_pin_in directly
`timescale 1ns/1ps
module tb;
    import sspseq_pkg::*;
    logic clk_in;
    logic rst_n_in;
    logic [7:0] addr_in;
    logic [31:0] wdata_in;
    logic wr_in;
    logic rd_in;
    logic [31:0] rdata_out;
    logic [63:0] rtc_in;
    logic wake_pin_in;
    logic [2:0] pll_level_strap_in;
    logic core_en_out, ana_en_out, pll_en_out, io_en_out;
    logic core_pfm_out, ana_pfm_out, clk_gate_out;
    logic [2:0] pll_level_out;
    logic [3:0] state_out;
    int err_count = 0;
    int checked = 0;
    int n;

    sspseq_top i_dut (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .rdata_out(rdata_out),
        .rtc_in(rtc_in),
        .wake_pin_in(wake_pin_in),
        .pll_level_strap_in(pll_level_strap_in),
        .core_en_out(core_en_out),
        .ana_en_out(ana_en_out),
        .pll_en_out(pll_en_out),
        .io_en_out(io_en_out),
        .core_pfm_out(core_pfm_out),
        .ana_pfm_out(ana_pfm_out),
        .clk_gate_out(clk_gate_out),
        .pll_level_out(pll_level_out),
        .state_out(state_out)
    );

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic end_of_test;
        $display("checked %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr

    // Read data only stands in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk($sformatf("rdata at %h", a), exp, rdata_out);
    endtask : rd

    // Expected pins come from the config word itself
    task automatic chk_out(input logic [31:0] c);
        chk("supply outputs", {25'h0, c[14], c[9], c[8], c[5], c[4], c[1], c[0]},
            {25'h0, clk_gate_out, ana_pfm_out, core_pfm_out, io_en_out, pll_en_out,
             ana_en_out, core_en_out});
    endtask : chk_out

    task automatic wait_state(input logic [3:0] s, input int bound);
        for (int i = 0; i <= bound; i++) begin
            @(posedge clk_in);
            #1;
            if (state_out === s) return;
        end
        err_count++;
        $display("unexpected state wait: expected %h, seen %h", s, state_out);
        end_of_test();
    endtask : wait_state

    // Cycles spent in state s, counted from the cycle it was seen
    task automatic dwell_len(input logic [3:0] s, output int len);
        len = 0;
        while (state_out === s && len <= 10000) begin
            @(posedge clk_in);
            #1;
            len++;
        end
        if (state_out === s) begin
            err_count++;
            $display("unexpected dwell wait: expected %h, seen %h", s, state_out);
            end_of_test();
        end
    endtask : dwell_len

    initial begin
        rst_n_in = 1'b0;
        addr_in = 8'h00;
        wdata_in = 32'h0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        rtc_in = 64'h0;
        wake_pin_in = 1'b0;
        pll_level_strap_in = 3'h5;
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        #1;
        chk_out(32'h0000_0033);
        chk("state", 32'h1, {28'h0, state_out});
        rd(8'h00, 32'h0000_0008);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h0C, 32'h0010_0000);
        rd(8'h1C, 32'h0010_0022);
        rd(8'h20, 32'h0010_0000);
        rd(8'h40, 32'h0000_0005);
        rd(8'h10, 32'h0);
        rd(8'h44, 32'h1);
        // Access kinds: reserved and read-only bits hold
        wr(8'h0C, 32'hFFFF_FFFF);
        rd(8'h0C, 32'h001F_4331);
        wr(8'h1C, 32'h0);
        rd(8'h1C, 32'h0000_0002);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_0007);
        chk("pll level", 32'h7, {29'h0, pll_level_out});
        wr(8'h40, 32'h0000_0003);
        rd(8'h40, 32'h0000_0003);
        wr(8'h44, 32'h0);
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h44, 32'h1);
        rd(8'h10, 32'h0);
        wr(8'h04, 32'h1234_5678);
        wr(8'h08, 32'h0000_00A5);
        rd(8'h04, 32'h1234_5678);
        rd(8'h08, 32'h0000_00A5);
        // Narrow compare: high word ignored
        wr(8'h1C, 32'h0002_4111);
        wr(8'h20, 32'h0002_0220);
        wr(8'h0C, 32'h0003_4301);
        wr(8'h00, 32'h0000_0013);
        wait_state(4'h2, 10);
        // Bit 1 keeps the value left from reset, the write cannot clear it
        chk_out(32'h0002_4113);
        dwell_len(4'h2, n);
        chk("first dwell", 32'h5, n);
        wait_state(4'h4, 10);
        chk_out(32'h0002_0220);
        wait_state(4'h8, 20);
        chk_out(32'h0003_4301);
        rd(8'h00, 32'h0000_0011);
        repeat (30) @(posedge clk_in);
        #1;
        chk("state", 32'h8, {28'h0, state_out});
        @(posedge clk_in);
        rtc_in <= {32'hDEAD_BEEF, 32'h1234_5678};
        wait_state(4'h1, 20);
        chk_out(32'h0000_0033);
        // Wide compare: low word match alone is not enough
        wr(8'h00, 32'h0000_0033);
        wait_state(4'h8, 40);
        repeat (60) @(posedge clk_in);
        #1;
        chk("state", 32'h8, {28'h0, state_out});
        @(posedge clk_in);
        rtc_in <= {32'h0000_00A5, 32'h1234_5678};
        wait_state(4'h1, 20);
        // Wake already true: dwell still has to run out
        wr(8'h0C, 32'h0005_4301);
        wr(8'h00, 32'h0000_0033);
        wait_state(4'h8, 40);
        dwell_len(4'h8, n);
        chk("hold dwell", 32'h1, {31'h0, n >= 32 && n <= 36});
        // Slow clock and pin wake: two slow ticks minimum
        wr(8'h0C, 32'h0001_0000);
        @(posedge clk_in);
        wake_pin_in <= 1'b1;
        wr(8'h00, 32'h0000_000E);
        wait_state(4'h8, 40);
        chk_out(32'h0001_0000);
        dwell_len(4'h8, n);
        chk("slow dwell", 32'h1, {31'h0, n >= 3000 && n <= 7000});
        chk("state", 32'h1, {28'h0, state_out});
        wake_pin_in <= 1'b0;
        end_of_test();
    end
endmodule : tb
